/* core/socket_regs_pkg.sv */
/*
  socket_regs_pkg: offsets, field positions, reset values and timing counts
  for the socket status / force register block.
  assumes: a 100 MHz bus clock; included by the design before its modules.
*/
package socket_regs_pkg;

  // register byte offsets
  localparam logic [7:0] socket_status_off = 8'h08;
  localparam logic [7:0] socket_force_off = 8'h0c;

  // status / force field positions
  localparam int ready_irq_pos = 6;
  localparam int cardbus_pos = 5;
  localparam int legacy_pos = 4;
  localparam int power_pos = 3;
  localparam int detect_b_pos = 2;
  localparam int detect_a_pos = 1;
  localparam int status_change_pos = 0;
  localparam int reinterrogate_pos = 14;
  localparam int volt_lo_pos = 10;
  localparam int volt_hi_pos = 13;
  localparam int bad_supply_pos = 9;
  localparam int loss_pos = 8;
  localparam int unknown_pos = 7;

  // values after reset
  localparam logic [3:0] volt_cap_reset = 4'h0;
  localparam logic [1:0] card_type_reset = 2'h0;
  localparam logic [31:0] read_zero = 32'h0000_0000;

  // interrogation timing
  localparam int clk_period_ns = 10;
  localparam int interrogate_ns = 1000;
  localparam int interrogate_cycles =
    (interrogate_ns / clk_period_ns) < 1 ? 1 :
    (interrogate_ns / clk_period_ns);
  localparam logic [7:0] interrogate_count =
    8'(interrogate_cycles - 1);

  // axi response codes
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  // interrogation sequencer states
  typedef enum logic [0:0] {
    idle_state = 1'b0,
    probe_state = 1'b1
  } probe_state_type;

endpackage

/* core/socket_status_force_regs.sv */
/*
  socket_status_force_regs: read-only socket status register and write-only
  force register behind an axi4-lite slave.
  assumes: card pins arrive asynchronously; event register and socket power
  control live elsewhere and consume the pulses and enable driven here.
  socket_power_state and the probe_* results come from logic on aclk; the
  probe results must be settled by the last cycle of an interrogation.
  card_inserted is a one-cycle pulse on aclk.
  limitation: a retrigger while a probe runs is absorbed by that probe.
*/
`timescale 1ns/10ps
// How it works
// - status bit 6 shows live ready/irq pin level
// - bit 5 cardbus flag changes on an interrogation or a force write
// - bit 4 legacy flag held until next interrogation or force write
// - bit 3 reports socket power, 0 down at reset, 1 up
// - bits 2 and 1 follow the two card-detect pin levels
// - card-detect bits frozen while an interrogation runs
// - bit 0 shows live card status-change pin level
// - force register at 0ch alters event and status bits
// - force bit 14 reinterrogates, updates status, enables power control
// - force bits 13..10 load voltage capability status bits
// - a forced voltage bit of 1 disables power control
// - force bit 9 sets bad supply request bit to written value
// - force bits 8 and 7 load loss and unknown-card flags
// - force bits 5 and 4 load cardbus and legacy flags
// - force bits 3..0 pulse the matching socket event bits
// - forcing events leaves status bits 3..0 untouched
// - force bits 31..15 read as zero
// - force bit 6 reads zero, writes ignored
// - forced values appear in the status register read
module socket_status_force_regs
  import socket_regs_pkg::*;
(
  input wire logic aclk, // bus clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic ready_irq_level, // card ready/irq pin
  input wire logic detect_pin_b_level, // second card-detect pin
  input wire logic detect_pin_a_level, // first card-detect pin
  input wire logic status_change_pin_level, // card status-change pin
  input wire logic socket_power_state, // socket power up, from power logic
  input wire logic probe_cardbus, // interrogation result: cardbus card
  input wire logic probe_legacy, // interrogation result: 16-bit card
  input wire logic [3:0] probe_volt_cap, // interrogation result: volt caps
  input wire logic card_inserted, // pulse from insertion logic
  output logic probe_busy, // interrogation in progress
  output logic power_ctrl_enable, // socket power control enabled
  output logic power_event, // pulse: set power event bit
  output logic detect_b_event, // pulse: set second detect event bit
  output logic detect_a_event, // pulse: set first detect event bit
  output logic status_change_event // pulse: set status-change event bit
);

  // pin synchronisers, three stages each
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic [3:0] pin_s3_q;
  logic [3:0] pin_q;

  // status state; everything but detect_q and the live pins is a flag
  // that holds until a probe or a force write loads it again
  logic cardbus_type_flag;
  logic legacy_type_flag;
  logic [3:0] volt_cap_q;
  logic bad_supply_req;
  logic loss_flag;
  logic unknown_card;
  logic [1:0] detect_q;

  // interrogation sequencer
  probe_state_type state_q;
  // probe_cnt_q holds the cycles left in the running probe
  logic [7:0] probe_cnt_q;
  logic probe_start;
  logic probe_done; // last probe cycle: results are loaded here

  // bus slave state; held address and data let aw and w come on
  // different edges
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  logic force_hit;
  logic [31:0] force_data;
  logic [31:0] status_word;

  // three flops per pin; a change counts once stages two and three agree.
  // bit order: 3 ready/irq, 2 detect b, 1 detect a, 0 status change.
  // detect pins reset high (no card) so the status word does not show a
  // card for the few cycles before the real pin levels arrive
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= 4'h6;
      pin_s2_q <= 4'h6;
      pin_s3_q <= 4'h6;
    end else begin
      pin_s1_q <= {ready_irq_level, detect_pin_b_level,
                   detect_pin_a_level, status_change_pin_level};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // filtered pin levels; a one-cycle glitch that reaches stage two only
  // never agrees with stage three and so never reaches the status word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q <= 4'h6;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (pin_s2_q[i] == pin_s3_q[i]) begin
          pin_q[i] <= pin_s3_q[i];
        end
      end
    end
  end

  // card-detect bits stop tracking while the probe drives the pins;
  // they catch up with the filtered levels on the first idle cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      detect_q <= 2'h3;
    end else if (state_q == idle_state) begin
      detect_q <= pin_q[2:1];
    end
  end

  // write channel acceptance, address and data in either order.
  // both readies stay low while bvalid is up, so at most one write is
  // under way and the response can never be overwritten
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

  // write address, held until the write is carried out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  // write data and strobes, held until the write is carried out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  // write response one cycle after both halves are held; writes to the
  // read-only status word are dropped but still answered okay, and any
  // other offset gets slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= resp_okay;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (awaddr_q[7:2] == socket_force_off[7:2]) begin
        s_axi_bresp <= resp_okay;
      end else if (awaddr_q[7:2] == socket_status_off[7:2]) begin
        s_axi_bresp <= resp_okay; // read-only: write ignored
      end else begin
        s_axi_bresp <= resp_slverr;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // force write, masked by byte strobes; bit 6 and 31..15 have no storage.
  // an unstrobed lane reads as zero here: no event pulse from lane 0 and,
  // below, no load of the status fields that lane carries
  assign force_hit = do_write &&
    (awaddr_q[7:2] == socket_force_off[7:2]);
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      force_data[b*8 +: 8] = wstrb_q[b] ? wdata_q[b*8 +: 8] : 8'h00;
    end
  end
  assign probe_start = force_hit && wstrb_q[1] &&
    force_data[reinterrogate_pos];

  // event pulses; a written 0 raises nothing
  // registered so each pulse lines up with the rise of bvalid and lasts
  // exactly one cycle; the event register does the sticky part
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_event <= 1'b0;
      detect_b_event <= 1'b0;
      detect_a_event <= 1'b0;
      status_change_event <= 1'b0;
    end else begin
      power_event <= force_hit && force_data[power_pos];
      detect_b_event <= force_hit && force_data[detect_b_pos];
      detect_a_event <= force_hit && force_data[detect_a_pos];
      status_change_event <= force_hit && force_data[status_change_pos];
    end
  end

  // interrogation sequencer; runs interrogate_cycles cycles, counting
  // down to zero. a retrigger while probing is absorbed: the running probe
  // already refreshes the status at its end, and ignoring it keeps the
  // probe length fixed for the power logic that waits on it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= idle_state;
      probe_cnt_q <= 8'h00;
    end else begin
      case (state_q)
        idle_state: begin
          if (probe_start || card_inserted) begin
            state_q <= probe_state;
            probe_cnt_q <= interrogate_count;
          end
        end
        probe_state: begin
          if (probe_cnt_q == 8'h00) begin
            state_q <= idle_state;
          end else begin
            probe_cnt_q <= probe_cnt_q - 8'h01;
          end
        end
        default: begin
          state_q <= idle_state;
        end
      endcase
    end
  end
  assign probe_busy = (state_q == probe_state);

  // last probe cycle; results, caps and power enable all load on it
  assign probe_done = probe_busy && (probe_cnt_q == 8'h00);

  // card type: probe result at the end, or a forced load
  // the probe wins a tie with a same-cycle force, as the probe is the
  // newer look at the card
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cardbus_type_flag <= card_type_reset[1];
      legacy_type_flag <= card_type_reset[0];
    end else if (probe_done) begin
      cardbus_type_flag <= probe_cardbus;
      legacy_type_flag <= probe_legacy;
    end else if (force_hit && wstrb_q[0]) begin
      cardbus_type_flag <= force_data[cardbus_pos];
      legacy_type_flag <= force_data[legacy_pos];
    end
  end

  // voltage capability bits, probed or forced; bit order 13 y, 12 x,
  // 11 3.3 v, 10 5 v, same as in the status word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      volt_cap_q <= volt_cap_reset;
    end else if (probe_done) begin
      volt_cap_q <= probe_volt_cap;
    end else if (force_hit && wstrb_q[1]) begin
      volt_cap_q <= force_data[volt_hi_pos:volt_lo_pos];
    end
  end

  // supply, loss and unknown-card flags only move when forced; nothing in
  // this block sets them on its own, so each holds its last forced value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bad_supply_req <= 1'b0;
      loss_flag <= 1'b0;
      unknown_card <= 1'b0;
    end else if (force_hit) begin
      if (wstrb_q[1]) begin
        bad_supply_req <= force_data[bad_supply_pos];
        loss_flag <= force_data[loss_pos];
      end
      if (wstrb_q[0]) begin
        unknown_card <= force_data[unknown_pos];
      end
    end
  end

  // power control: off by forced caps, back on at the end of any probe.
  // a forced cap beats a probe ending in the same cycle, so software
  // that forces caps in that cycle is not overruled by the ending probe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_ctrl_enable <= 1'b1;
    end else if (force_hit && wstrb_q[1] &&
                 force_data[volt_hi_pos:volt_lo_pos] != 4'h0) begin
      power_ctrl_enable <= 1'b0;
    end else if (probe_done) begin
      power_ctrl_enable <= 1'b1;
    end
  end

  // status word; bits 3..0 never see force data
  // built from live state each cycle; the read channel registers it, so
  // a read shows the state as it was when the address was taken
  always_comb begin
    status_word = read_zero;
    status_word[volt_hi_pos:volt_lo_pos] = volt_cap_q;
    status_word[bad_supply_pos] = bad_supply_req;
    status_word[loss_pos] = loss_flag;
    status_word[unknown_pos] = unknown_card;
    status_word[ready_irq_pos] = pin_q[3];
    status_word[cardbus_pos] = cardbus_type_flag;
    status_word[legacy_pos] = legacy_type_flag;
    status_word[power_pos] = socket_power_state;
    status_word[detect_b_pos:detect_a_pos] = detect_q;
    status_word[status_change_pos] = pin_q[0];
  end

  // read channel: one outstanding read, data registered. arready drops
  // while rvalid is up, so an answer can never be replaced before rready
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= read_zero;
      s_axi_rresp <= resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr[7:2] == socket_status_off[7:2]) begin
        s_axi_rdata <= status_word;
        s_axi_rresp <= resp_okay;
      end else if (s_axi_araddr[7:2] == socket_force_off[7:2]) begin
        s_axi_rdata <= read_zero;
        s_axi_rresp <= resp_okay;
      end else begin
        s_axi_rdata <= read_zero;
        s_axi_rresp <= resp_slverr;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

/* tb/socket_status_force_regs_monitor.sv */
/*
  socket_status_force_regs_monitor: port-level assertions for the socket
  status / force block.
  assumes: bound to every instance of the top module, one clock domain.
*/
`timescale 1ns/10ps
module socket_status_force_regs_monitor
  import socket_regs_pkg::*;
(
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // strobes
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic probe_busy, // probing
  input wire logic power_ctrl_enable, // power control on
  input wire logic power_event, // event pulse
  input wire logic detect_b_event, // event pulse
  input wire logic detect_a_event, // event pulse
  input wire logic status_change_event // event pulse
);
  default clocking mon_cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] busy_q;
  logic [7:0] busy_d;
  logic wr_go;
  logic any_ev;
  // probe length counter; a stuck probe trips busy_cap_a long before wrap
  assign busy_d = probe_busy ? busy_q + 8'h01 : 8'h00;
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready;
  assign any_ev = power_event || detect_b_event || detect_a_event ||
    status_change_event;
  always_ff @(posedge aclk) begin
    if (!aresetn) busy_q <= 8'h00;
    else busy_q <= busy_d;
  end
  probe_len_a: assert property ($fell(probe_busy) |->
    busy_q == 8'(interrogate_cycles)) else $error("probe length wrong");
  busy_cap_a: assert property (busy_q <= 8'(interrogate_cycles))
    else $error("probe overran");
  pwr_on_a: assert property ($fell(probe_busy) |->
    power_ctrl_enable) else $error("power control not re-enabled");
  cap_off_a: assert property (wr_go &&
    s_axi_awaddr == socket_force_off && s_axi_wstrb[1] &&
    s_axi_wdata[13:10] != 4'h0 |-> ##[1:3] !power_ctrl_enable)
    else $error("power control not disabled");
  wr_lat_a: assert property (wr_go |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  ev_pair_a: assert property (any_ev |-> $rose(s_axi_bvalid))
    else $error("event pulse not tied to a write");
  ev_once_a: assert property (any_ev |=> !any_ev)
    else $error("event pulse too long");
  rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  rd_done_a: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid) else $error("read answer not released");
  cover property ($fell(probe_busy));
  cover property (power_event);
  cover property (wr_go ##2 s_axi_bvalid);
endmodule

bind socket_status_force_regs socket_status_force_regs_monitor mon (.*);

/* tb/socket_status_force_regs_tb.sv */
/*
  socket_status_force_regs_tb: directed bench for the status / force block.
  assumes: axi4-lite master built here, pins and probe results driven here.
*/
`timescale 1ns/10ps
module socket_status_force_regs_tb
  import socket_regs_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, ready_irq_level;
  logic detect_pin_b_level, detect_pin_a_level, status_change_pin_level;
  logic socket_power_state, probe_cardbus, probe_legacy, card_inserted;
  logic probe_busy, power_ctrl_enable, power_event, detect_b_event;
  logic detect_a_event, status_change_event;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, probe_volt_cap, ev_seen;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  int bad_count, n_checks;

  socket_status_force_regs dut (.*);

  always #5 aclk = ~aclk;

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic timeout;
    bad_count++;
    stop_test();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one write; gathers event pulses seen until the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    ev_seen = 4'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      ev_seen = ev_seen | {power_event, detect_b_event, detect_a_event,
        status_change_event};
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n > 50) timeout();
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n > 50) timeout();
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // status bits 13..0 only; the upper socket bits live elsewhere
  task automatic st(input logic [31:0] exp);
    rd_reg(socket_status_off);
    chk(rd & 32'h0000_3fff, exp);
  endtask

  // pins pass a synchroniser and filter, 4 edges; 8 leaves margin
  task automatic settle;
    repeat (8) @(posedge aclk);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (n > 300) timeout();
    end while (probe_busy);
  endtask

  task automatic t_idle;
    st(32'h0000_0045);
    chk({31'h0, power_ctrl_enable}, 32'h1);
    rd_reg(socket_force_off);
    chk(rd, 32'h0);
    @(posedge aclk);
    ready_irq_level <= 1'b0;
    detect_pin_b_level <= 1'b0;
    detect_pin_a_level <= 1'b1;
    status_change_pin_level <= 1'b0;
    socket_power_state <= 1'b1;
    settle();
    st(32'h0000_000a);
  endtask

  task automatic t_flags;
    wr(socket_force_off, 32'h0000_3ff0);
    chk({30'h0, rs}, {30'h0, resp_okay});
    st(32'h0000_3fba);
    chk({31'h0, power_ctrl_enable}, 32'h0);
    rd_reg(socket_force_off);
    chk(rd, 32'h0);
    wr(socket_force_off, 32'h0);
    chk({28'h0, ev_seen}, 32'h0);
    st(32'h0000_000a);
    s_axi_wstrb <= 4'h2;
    wr(socket_force_off, 32'h0000_3fff);
    s_axi_wstrb <= 4'hf;
    chk({28'h0, ev_seen}, 32'h0);
    st(32'h0000_3f0a);
    wr(socket_force_off, 32'h0);
    wr(socket_status_off, 32'h0000_3ff0);
    chk({30'h0, rs}, {30'h0, resp_okay});
    st(32'h0000_000a);
    rd_reg(8'h10);
    chk({30'h0, rs}, {30'h0, resp_slverr});
  endtask

  task automatic t_events;
    for (int i = 0; i < 4; i++) begin
      wr(socket_force_off, 32'h1 << i);
      chk({28'h0, ev_seen}, 32'h1 << i);
    end
    st(32'h0000_000a);
  endtask

  task automatic t_probe;
    @(posedge aclk);
    probe_cardbus <= 1'b1;
    probe_volt_cap <= 4'h9;
    wr(socket_force_off, 32'h0000_4000);
    detect_pin_b_level <= 1'b1;
    detect_pin_a_level <= 1'b0;
    settle();
    st(32'h0000_000a);
    wait_idle();
    chk({31'h0, power_ctrl_enable}, 32'h1);
    settle();
    st(32'h0000_242c);
    probe_cardbus <= 1'b0;
    probe_legacy <= 1'b1;
    probe_volt_cap <= 4'h2;
    st(32'h0000_242c);
    card_inserted <= 1'b1;
    @(posedge aclk);
    card_inserted <= 1'b0;
    wait_idle();
    st(32'h0000_081c);
  endtask

  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    ready_irq_level = 1'b1;
    detect_pin_b_level = 1'b1;
    detect_pin_a_level = 1'b0;
    status_change_pin_level = 1'b1;
    socket_power_state = 1'b0;
    probe_cardbus = 1'b0;
    probe_legacy = 1'b0;
    probe_volt_cap = 4'h0;
    card_inserted = 1'b0;
    bad_count = 0;
    n_checks = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    settle();
    t_idle();
    t_flags();
    t_events();
    t_probe();
    stop_test();
  end
endmodule
